/* logic/apo_port.sv */
// Purpose: Parallel output port of a pipelined converter
// Assumes: Samples are produced on clock; words leave on sample_clk
// Notes: Data changes on the falling sampling edge, strobe follows ~sample_clk

// Behaviour
// - Each rising sampling clock edge takes one new sample into conversion, or the idle word if none is buffered.
// - A sample's word appears four and a half sampling cycles after its capture edge.
// - Data and range flag change only on the falling sampling clock edge.
// - The ready strobe falls just after each rising sampling clock edge.
// - The ready strobe rises again one sampling clock high phase later.
// - The range flag is high for a sample beyond full scale, else low.
// - The word is thirteen bits, bit zero least and bit twelve most weighty.
// - Codes are offset binary, all zeros at the bottom, all ones at the top.
// - A level at the common-mode point gives the mid-scale code.
module apo_port
    import apo_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    // Sample source, system clock domain
    input wire apo_pkg::apo_sample_t sample_in,
    input wire logic sample_valid,
    output logic sample_ready,
    // Status, system clock domain
    output logic underrun_pulse,
    // Sampling clock from the link
    input wire logic sample_clk,
    // Parallel outputs, sampling clock domain
    output logic [apo_pkg::APO_WORD_W-1:0] word_bits,
    output logic range_exceeded_flag,
    output logic sample_ready_strobe
);
    import apo_pkg::*;

    // Link-side reset
    logic [1:0] link_rst_sync;
    logic link_rst;

    // Buffer read side
    logic [APO_SAMPLE_BITS-1:0] fifo_rd_data;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    apo_sample_t fifo_sample;

    // Conversion pipeline
    apo_word_t captured;
    apo_word_t pipe [APO_LATENCY];
    apo_word_t out_word;

    // Strobe toggles
    logic rise_tog;
    logic fall_tog;

    // Underrun event crossing
    logic underrun_tog;
    logic underrun_meta;
    logic underrun_sync;
    logic underrun_seen;

    // Reset release synchronised to the sampling clock
    always_ff @(posedge sample_clk or posedge rst)
    begin
        if (rst)
            link_rst_sync <= APO_RST_SYNC_INIT;
        else
            link_rst_sync <= {link_rst_sync[0], 1'b0};
    end
    assign link_rst = link_rst_sync[1];

    // Buffer between the sample source and the sampling domain
    apo_fifo #(
        .WIDTH(APO_SAMPLE_BITS),
        .DEPTH(APO_FIFO_DEPTH)
    ) u_fifo (
        .wr_clk(clock),
        .wr_rst(rst),
        .wr_data(sample_in),
        .wr_valid(sample_valid),
        .wr_ready(sample_ready),
        .rd_clk(sample_clk),
        .rd_rst(link_rst),
        .rd_data(fifo_rd_data),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_rd_ready)
    );

    // One sample drained on every rising edge that finds one, once out of reset
    assign fifo_rd_ready = !link_rst;
    assign fifo_sample = apo_sample_t'(fifo_rd_data);

    // Capture and encode on the rising sampling edge
    always_ff @(posedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
            captured <= APO_IDLE_WORD;
        else if (fifo_rd_valid)
            captured <= apo_encode(fifo_sample.level);
        else
            captured <= APO_IDLE_WORD;
    end

    // Note a capture edge that found no sample
    always_ff @(posedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
            underrun_tog <= 1'b0;
        else if (!fifo_rd_valid)
            underrun_tog <= ~underrun_tog;
    end

    // Pipeline stages, one per sampling cycle
    always_ff @(posedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            for (int i = 0; i < APO_LATENCY; i++)
                pipe[i] <= APO_RESET_WORD;
        end
        else
        begin
            pipe[0] <= captured;
            for (int i = 1; i < APO_LATENCY; i++)
                pipe[i] <= pipe[i-1];
        end
    end

    // Output register loads on the falling sampling edge
    always_ff @(negedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
            out_word <= APO_RESET_WORD;
        else
            out_word <= pipe[APO_LATENCY-1];
    end

    // Bit zero least, bit twelve most significant
    assign word_bits = out_word.code;
    assign range_exceeded_flag = out_word.over;

    // Rising edge marks strobe low
    always_ff @(posedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
            rise_tog <= 1'b0;
        else
            rise_tog <= ~rise_tog;
    end

    // Falling edge marks strobe high, with the data update
    always_ff @(negedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
            fall_tog <= 1'b0;
        else
            fall_tog <= rise_tog;
    end

    // Strobe low from rising edge to the end of the high phase
    assign sample_ready_strobe = (rise_tog == fall_tog);

    // Underrun toggle into the system domain
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            underrun_meta <= 1'b0;
            underrun_sync <= 1'b0;
            underrun_seen <= 1'b0;
        end
        else
        begin
            underrun_meta <= underrun_tog;
            underrun_sync <= underrun_meta;
            underrun_seen <= underrun_sync;
        end
    end

    // One system cycle pulse per missed sample
    assign underrun_pulse = underrun_sync ^ underrun_seen;

endmodule

/* common/apo_pkg.sv */
// Purpose: Shared constants, types and helpers for the converter output port
// Assumes: Samples arrive as signed levels scaled so full scale is +/-4096
// Notes: Output codes are offset binary, 13 bits wide
package apo_pkg;

    // Output word geometry
    localparam int APO_WORD_W = 13;
    localparam int APO_LEVEL_W = 16;

    // Sampling clock cycles from the capture register to the last pipeline stage
    localparam int APO_LATENCY = 4;

    // Depth of the input buffer
    localparam int APO_FIFO_DEPTH = 8;

    // Code values
    localparam logic [APO_WORD_W-1:0] APO_MID_CODE = 13'h1000;
    localparam logic [APO_WORD_W-1:0] APO_ZERO_CODE = 13'h0000;
    localparam logic [APO_WORD_W-1:0] APO_ONES_CODE = 13'h1FFF;

    // Largest and smallest levels inside full scale
    localparam logic signed [APO_LEVEL_W-1:0] APO_LEVEL_MAX = 16'sh0FFF;
    localparam logic signed [APO_LEVEL_W-1:0] APO_LEVEL_MIN = 16'shF000;

    // Bias that moves a signed level to offset binary
    localparam logic signed [APO_LEVEL_W:0] APO_BIAS = 17'sh01000;

    // Reset values of the link-side reset synchroniser
    localparam logic [1:0] APO_RST_SYNC_INIT = 2'h3;

    // One sample from the digitising core
    typedef struct packed {
        logic signed [APO_LEVEL_W-1:0] level;
    } apo_sample_t;

    // One output word with its range flag
    typedef struct packed {
        logic over;
        logic [APO_WORD_W-1:0] code;
    } apo_word_t;

    localparam int APO_SAMPLE_BITS = $bits(apo_sample_t);

    // Idle word shown when no sample was available, and the word shown after reset
    localparam apo_word_t APO_IDLE_WORD = '{over: 1'b0, code: APO_MID_CODE};
    localparam apo_word_t APO_RESET_WORD = '{over: 1'b0, code: APO_ZERO_CODE};

    // Encode a signed level to offset binary with clipping and range flag
    function automatic apo_word_t apo_encode(
        input logic signed [APO_LEVEL_W-1:0] level
    );
        apo_word_t w;
        logic signed [APO_LEVEL_W:0] biased;
        biased = {level[APO_LEVEL_W-1], level} + APO_BIAS;
        if (level > APO_LEVEL_MAX)
        begin
            w.over = 1'b1;
            w.code = APO_ONES_CODE;
        end
        else if (level < APO_LEVEL_MIN)
        begin
            w.over = 1'b1;
            w.code = APO_ZERO_CODE;
        end
        else
        begin
            w.over = 1'b0;
            w.code = biased[APO_WORD_W-1:0];
        end
        return w;
    endfunction

endpackage

/* logic/apo_fifo.sv */
// Purpose: Dual-clock FIFO carrying samples into the sampling clock domain
// Assumes: Depth is a power of two, at least four
// Notes: Gray-coded pointers cross through two flip-flops each
module apo_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Write side
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // Read side
    input wire logic rd_clk,
    input wire logic rd_rst,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] PTR_ONE = 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wbin;
    logic [PW-1:0] wgray;
    logic [PW-1:0] rbin;
    logic [PW-1:0] rgray;
    logic [PW-1:0] rgray_meta;
    logic [PW-1:0] rgray_sync;
    logic [PW-1:0] wgray_meta;
    logic [PW-1:0] wgray_sync;
    logic [PW-1:0] next_wbin;
    logic [PW-1:0] next_rbin;
    logic wr_fire;
    logic rd_fire;

    // Binary to gray for pointer crossing
    function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Full when write gray equals read gray with top two bits inverted
    assign wr_ready = (wgray != {~rgray_sync[PW-1:PW-2], rgray_sync[PW-3:0]});
    assign rd_valid = (rgray != wgray_sync);
    assign wr_fire = wr_valid && wr_ready;
    assign rd_fire = rd_valid && rd_ready;
    assign next_wbin = wbin + PTR_ONE;
    assign next_rbin = rbin + PTR_ONE;
    assign rd_data = mem[rbin[AW-1:0]];

    // Storage write
    always_ff @(posedge wr_clk)
    begin
        if (wr_fire)
            mem[wbin[AW-1:0]] <= wr_data;
    end

    // Write pointer
    always_ff @(posedge wr_clk or posedge wr_rst)
    begin
        if (wr_rst)
        begin
            wbin <= '0;
            wgray <= '0;
        end
        else if (wr_fire)
        begin
            wbin <= next_wbin;
            wgray <= to_gray(next_wbin);
        end
    end

    // Read pointer into the write domain
    always_ff @(posedge wr_clk or posedge wr_rst)
    begin
        if (wr_rst)
        begin
            rgray_meta <= '0;
            rgray_sync <= '0;
        end
        else
        begin
            rgray_meta <= rgray;
            rgray_sync <= rgray_meta;
        end
    end

    // Read pointer
    always_ff @(posedge rd_clk or posedge rd_rst)
    begin
        if (rd_rst)
        begin
            rbin <= '0;
            rgray <= '0;
        end
        else if (rd_fire)
        begin
            rbin <= next_rbin;
            rgray <= to_gray(next_rbin);
        end
    end

    // Write pointer into the read domain
    always_ff @(posedge rd_clk or posedge rd_rst)
    begin
        if (rd_rst)
        begin
            wgray_meta <= '0;
            wgray_sync <= '0;
        end
        else
        begin
            wgray_meta <= wgray;
            wgray_sync <= wgray_meta;
        end
    end

endmodule

/* testbench/apo_port_properties.sv */
// Purpose: Timing checks on the converter output port
// Assumes: Link side settles five sampling edges after reset
// Notes: Bound to every apo_port instance
module apo_port_chk
    import apo_pkg::*;
(
    // Clocks and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic sample_clk,
    // Status
    input wire logic sample_ready,
    input wire logic underrun_pulse,
    // Outputs
    input wire logic [apo_pkg::APO_WORD_W-1:0] word_bits,
    input wire logic range_exceeded_flag,
    input wire logic sample_ready_strobe
);
    logic [2:0] edges;
    logic [APO_WORD_W:0] at_rise;
    logic live;
    // Startup edge count
    always_ff @(posedge sample_clk or posedge rst)
    begin
        if (rst)
            edges <= 3'h0;
        else if (edges != 3'h5)
            edges <= edges + 3'h1;
    end
    // Output seen at the rising edge
    always_ff @(posedge sample_clk)
    begin
        at_rise <= {range_exceeded_flag, word_bits};
    end
    assign live = (edges == 3'h5);
    chk_strobe_low: assert property (
        @(negedge sample_clk) disable iff (rst) live |-> !sample_ready_strobe)
        else $error("strobe high in high phase");
    chk_strobe_back: assert property (
        @(posedge sample_clk) disable iff (rst) live |-> sample_ready_strobe)
        else $error("strobe low at rising edge");
    chk_word_hold: assert property (
        @(negedge sample_clk) disable iff (rst)
        live |-> word_bits == at_rise[APO_WORD_W-1:0])
        else $error("word moved in high phase");
    chk_flag_hold: assert property (
        @(negedge sample_clk) disable iff (rst)
        live |-> range_exceeded_flag == at_rise[APO_WORD_W])
        else $error("flag moved in high phase");
    chk_over_code: assert property (
        @(negedge sample_clk) disable iff (rst) live && range_exceeded_flag
        |-> word_bits == APO_ZERO_CODE || word_bits == APO_ONES_CODE)
        else $error("flag with inner code");
    chk_change_pair: assert property (
        @(posedge clock) disable iff (rst)
        live && $changed(word_bits) |-> $rose(sample_ready_strobe))
        else $error("word change without strobe rise");
    chk_fall_quiet: assert property (
        @(posedge clock) disable iff (rst) $fell(sample_ready_strobe)
        |-> $stable(word_bits) && $stable(range_exceeded_flag))
        else $error("word change at strobe fall");
    chk_pulse_one: assert property (
        @(posedge clock) disable iff (rst) underrun_pulse |=> !underrun_pulse)
        else $error("underrun pulse too long");
    cover property (@(posedge clock) underrun_pulse);
    cover property (@(negedge sample_clk) range_exceeded_flag);
    cover property (@(posedge clock) !sample_ready);
endmodule

bind apo_port apo_port_chk u_chk (.clock(clock), .rst(rst),
    .sample_clk(sample_clk), .sample_ready(sample_ready),
    .underrun_pulse(underrun_pulse), .word_bits(word_bits),
    .range_exceeded_flag(range_exceeded_flag),
    .sample_ready_strobe(sample_ready_strobe));

/* testbench/apo_rx.sv */
// Purpose: Capture logic beside the converter output port
// Assumes: Data settles before the strobe has been high 2 ns
// Notes: Every strobed word is queued for the bench
module apo_rx
    import apo_pkg::*;
(
    // Port outputs
    input wire logic [apo_pkg::APO_WORD_W-1:0] word_bits,
    input wire logic range_exceeded_flag,
    input wire logic sample_ready_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    apo_word_t q[$];
    // Word and flag taken on one strobe edge
    always @(posedge sample_ready_strobe)
    begin
        #2 q.push_back('{over: range_exceeded_flag, code: word_bits});
    end
endmodule

/* testbench/tb.sv */
// Purpose: Self-checking bench for the converter output port
// Assumes: Capture model queues every strobed word
// Notes: Sampling clock unrelated in phase to the system clock
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import apo_pkg::*;
    logic clock;
    logic rst;
    logic sample_clk;
    apo_sample_t sample_in;
    logic sample_valid;
    logic sample_ready;
    logic underrun_pulse;
    logic [APO_WORD_W-1:0] word_bits;
    logic range_exceeded_flag;
    logic sample_ready_strobe;
    int fail_count;
    int check_count;
    int rises;
    int unders;
    apo_port uut (.clock(clock), .rst(rst), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .underrun_pulse(underrun_pulse), .sample_clk(sample_clk),
        .word_bits(word_bits), .range_exceeded_flag(range_exceeded_flag),
        .sample_ready_strobe(sample_ready_strobe));
    apo_rx rx (.word_bits(word_bits),
        .range_exceeded_flag(range_exceeded_flag),
        .sample_ready_strobe(sample_ready_strobe));
    // Clocks
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        sample_clk = 1'b0;
        #7;
        forever #24 sample_clk = ~sample_clk;
    end
    // Edge and underrun counts
    always @(posedge sample_clk) rises++;
    always @(posedge clock) if (underrun_pulse === 1'b1) unders++;
    task automatic end_sim();
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp_word(string what, apo_word_t exp, apo_word_t got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_true(string what, logic ok);
        check_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("[FAIL] %s expected 1 seen %b", what, ok);
            if (what == "wait") end_sim();
        end
    endtask
    function automatic apo_word_t exp_word(int lvl);
        if (lvl > 4095) return '{over: 1'b1, code: APO_ONES_CODE};
        if (lvl < -4096) return '{over: 1'b1, code: APO_ZERO_CODE};
        return '{over: 1'b0, code: 13'(lvl + 4096)};
    endfunction
    // Offer one level until taken; valid stays up
    task automatic push(int lvl, inout logic refused);
        logic ok;
        int i;
        ok = 1'b0;
        sample_in = '{level: lvl[15:0]};
        sample_valid = 1'b1;
        for (i = 0; i < 200 && !ok; i++)
        begin
            @(negedge clock);
            ok = (sample_ready === 1'b1);
            refused = refused | !ok;
            @(posedge clock);
        end
        #1;
        cmp_true("wait", ok);
    endtask
    // Sixteen codes across the range, enough that the buffer refuses some
    task automatic t_stream();
        int lv[10] = '{100, 0, 4095, -4096, 4096, -4097, 1, -1, 32767, -32768};
        logic refused;
        int i;
        int j;
        refused = 1'b0;
        rx.q.delete();
        for (i = 0; i < 16; i++) push(lv[i % 10], refused);
        sample_valid = 1'b0;
        cmp_true("refused", refused);
        for (i = 0; i < 400 && rx.q.size() < 48; i++) @(posedge clock);
        cmp_true("wait", rx.q.size() >= 48);
        j = 0;
        while (j < 30 && rx.q[j] !== exp_word(lv[0])) j++;
        for (i = 0; i < 16; i++)
            cmp_word("code", exp_word(lv[i % 10]), rx.q[j + i]);
    endtask
    // Lone sample after the buffer ran dry
    task automatic t_lone();
        logic refused;
        int r0;
        int i;
        refused = 1'b0;
        unders = 0;
        for (i = 0; i < 200 && unders == 0; i++) @(posedge clock);
        cmp_true("wait", unders > 0);
        // Let the last buffered words leave the pipeline first
        repeat (20) @(posedge clock);
        #1;
        rx.q.delete();
        r0 = rises;
        push(-3, refused);
        sample_valid = 1'b0;
        for (i = 0; i < 200 && !(rx.q.size() > 0 && rx.q[$] === exp_word(-3));
            i++) @(posedge clock);
        cmp_true("wait", i < 200);
        cmp_true("latency", rises - r0 >= 5 && rises - r0 <= 8);
        cmp_word("idle", APO_IDLE_WORD, rx.q[0]);
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        sample_in = '0;
        sample_valid = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        t_stream();
        t_lone();
        end_sim();
    end
endmodule
